// >>> hw/mafb_bank.sv
// Alarm-enable and fault-flag register bank with Avalon-MM slave
module mafb_bank (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic response_err,
  input wire logic [23:0] aux3_value,
  input wire logic [23:0] aux4_value,
  input wire logic [23:0] isum_value,
  input wire logic [23:0] psum_value,
  input wire logic [23:0] aux3_max,
  input wire logic [23:0] aux3_min,
  input wire logic [23:0] aux4_max,
  input wire logic [23:0] aux4_min,
  input wire logic [23:0] isum_max,
  input wire logic [23:0] isum_min,
  input wire logic [23:0] psum_max,
  input wire logic [23:0] psum_min,
  input wire logic aux_conv_done,
  input wire logic isum_conv_done,
  input wire logic psum_conv_done,
  input wire logic voltage_ready,
  input wire logic current_ready,
  input wire logic stuck_wake,
  input wire logic [3:0] pin_level_in,
  output logic stuck_wake_enable,
  output logic alarm_out
);
  logic [7:0] limit_enable_bits3_reg;
  logic [7:0] limit_fault_bits3_reg;
  logic [7:0] event_enable_bits4_reg;
  logic [7:0] event_fault_bits4_reg;
  logic [7:0] pin_io_control_bits_reg;
  logic alarm_flag_reg;
  logic [7:0] second_control_register_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic err_reg;
  logic [7:0] limit_fault_bits3_next;
  logic [7:0] event_fault_bits4_next;
  logic alarm_flag_next;

  // One wait state: answer comes on the cycle after the request is seen
  wire req = (read | write) & ~ack_reg;
  wire [7:0] idx = address[9:2];
  wire wr_ok = write & ack_reg & byteenable[0];
  wire [7:0] wd = writedata[7:0];
  wire sel_le3 = (idx == mafb_pkg::MAFB_IDX_LIMIT_ENABLE3);
  wire sel_lf3 = (idx == mafb_pkg::MAFB_IDX_LIMIT_LIMIT_FAULT_GROUP3);
  wire sel_ee4 = (idx == mafb_pkg::MAFB_IDX_EVENT_ENABLE4);
  wire sel_ef4 = (idx == mafb_pkg::MAFB_IDX_EVENT_EVENT_FAULT_GROUP4);
  wire sel_gs = (idx == mafb_pkg::MAFB_IDX_PIN_STATUS);
  wire sel_gio = (idx == mafb_pkg::MAFB_IDX_PIN_IO_CTRL);
  wire sel_gc = (idx == mafb_pkg::MAFB_IDX_PIN4_CTRL);
  wire sel_cb = (idx == mafb_pkg::MAFB_IDX_CONTROL_B);
  wire mapped = sel_le3 | sel_lf3 | sel_ee4 | sel_ef4 | sel_gs | sel_gio | sel_gc | sel_cb;

  // Comparisons are strict and qualified by the conversion strobe of each value
  wire [7:0] limit_hit;
  assign limit_hit[7] = aux_conv_done & (aux3_value > aux3_max);
  assign limit_hit[6] = aux_conv_done & (aux3_value < aux3_min);
  assign limit_hit[5] = aux_conv_done & (aux4_value > aux4_max);
  assign limit_hit[4] = aux_conv_done & (aux4_value < aux4_min);
  assign limit_hit[3] = isum_conv_done & (isum_value > isum_max);
  assign limit_hit[2] = isum_conv_done & (isum_value < isum_min);
  assign limit_hit[1] = psum_conv_done & (psum_value > psum_max);
  assign limit_hit[0] = psum_conv_done & (psum_value < psum_min);
  wire [7:0] limit_set = limit_hit & limit_enable_bits3_reg;

  // Pin level match: polarity 1 alarms on high, 0 on low
  wire [2:0] pin_match = ~(pin_level_in[3:1] ^ pin_io_control_bits_reg[3:1]);
  wire wake_hit = stuck_wake & second_control_register_reg[mafb_pkg::MAFB_SECOND_CONTROL_REGISTER_WAKE_BIT];
  wire [7:0] event_hit = {3'b000, wake_hit, pin_match, 1'b0};
  wire [7:0] event_set = event_hit & event_enable_bits4_reg & mafb_pkg::MAFB_EVENT4_MASK;
  wire rdy_alarm = (voltage_ready & event_enable_bits4_reg[mafb_pkg::MAFB_VRDY_BIT])
                 | (current_ready & event_enable_bits4_reg[mafb_pkg::MAFB_IRDY_BIT]);
  wire any_alarm = (|limit_set) | (|event_set) | rdy_alarm;

  // Software clears fault bits by writing 0; a new event in the same cycle wins
  wire [7:0] lf3_keep = (wr_ok & sel_lf3) ? (limit_fault_bits3_reg & wd) : limit_fault_bits3_reg;
  wire [7:0] ef4_keep = (wr_ok & sel_ef4) ? (event_fault_bits4_reg & wd) : event_fault_bits4_reg;
  wire flag_clr = (wr_ok & sel_gc & ~wd[mafb_pkg::MAFB_GC_FLAG_BIT])
                | (wr_ok & sel_cb & wd[mafb_pkg::MAFB_SECOND_CONTROL_REGISTER_CLEAR_BIT]);

  always_comb begin
    limit_fault_bits3_next = lf3_keep | limit_set;
    event_fault_bits4_next = (ef4_keep | event_set) & mafb_pkg::MAFB_EVENT_FAULT_GROUP4_MASK;
    alarm_flag_next = any_alarm | (alarm_flag_reg & ~flag_clr);
  end

  wire [7:0] rd_byte = sel_le3 ? limit_enable_bits3_reg :
                       sel_lf3 ? limit_fault_bits3_reg :
                       sel_ee4 ? event_enable_bits4_reg :
                       sel_ef4 ? event_fault_bits4_reg :
                       sel_gs ? {4'h0, pin_level_in} :
                       sel_gio ? pin_io_control_bits_reg :
                       sel_gc ? {alarm_flag_reg, 7'h00} :
                       sel_cb ? second_control_register_reg : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      limit_enable_bits3_reg <= 8'h00;
      event_enable_bits4_reg <= 8'h00;
      pin_io_control_bits_reg <= mafb_pkg::MAFB_PIN_IO_RESET;
      second_control_register_reg <= 8'h00;
    end else if (wr_ok) begin
      if (sel_le3) limit_enable_bits3_reg <= wd;
      if (sel_ee4) event_enable_bits4_reg <= wd & mafb_pkg::MAFB_EVENT4_MASK;
      if (sel_gio) pin_io_control_bits_reg <= wd & mafb_pkg::MAFB_PIN_IO_MASK;
      // Clear bit is self-clearing; only the wakeup bit is stored
      if (sel_cb) second_control_register_reg <= wd & 8'h10;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      limit_fault_bits3_reg <= 8'h00;
      event_fault_bits4_reg <= 8'h00;
      alarm_flag_reg <= 1'b0;
    end else begin
      limit_fault_bits3_reg <= limit_fault_bits3_next;
      event_fault_bits4_reg <= event_fault_bits4_next;
      alarm_flag_reg <= alarm_flag_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req;
      if (req) begin
        readdata_reg <= {24'h00_0000, rd_byte};
        err_reg <= ~mapped;
      end
    end
  end

  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata = readdata_reg;
  assign response_err = err_reg;
  assign stuck_wake_enable = second_control_register_reg[mafb_pkg::MAFB_SECOND_CONTROL_REGISTER_WAKE_BIT];
  assign alarm_out = alarm_flag_reg;

  property p_limit_set;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[7] & aux_conv_done & (aux3_value > aux3_max))
        |=> limit_fault_bits3_reg[7];
  endproperty
  a_limit_set: assert property (p_limit_set) else $error("aux3 over fault not set");

  property p_no_set_disabled;
    @(posedge ref_clk) disable iff (!rst_b)
      (!limit_fault_bits3_reg[3] & !limit_enable_bits3_reg[3]) |=> !limit_fault_bits3_reg[3];
  endproperty
  a_no_set_disabled: assert property (p_no_set_disabled) else $error("fault set while disabled");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_fault_bits3_reg[0] & !(wr_ok & sel_lf3)) |=> limit_fault_bits3_reg[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit dropped");

  property p_reserved4;
    @(posedge ref_clk) disable iff (!rst_b)
      ((event_fault_bits4_reg & 8'hE1) == 8'h00) && ((event_enable_bits4_reg & 8'h21) == 8'h00);
  endproperty
  a_reserved4: assert property (p_reserved4) else $error("reserved bit nonzero");

  property p_pin_fault;
    @(posedge ref_clk) disable iff (!rst_b)
      (event_enable_bits4_reg[3] & (pin_level_in[3] == pin_io_control_bits_reg[3]))
        |=> event_fault_bits4_reg[3] & alarm_out;
  endproperty
  a_pin_fault: assert property (p_pin_fault) else $error("pin1 fault missed");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_b)
      (stuck_wake & stuck_wake_enable & event_enable_bits4_reg[4]) |=> event_fault_bits4_reg[4];
  endproperty
  a_wake: assert property (p_wake) else $error("wake fault missed");

  property p_vrdy;
    @(posedge ref_clk) disable iff (!rst_b)
      (voltage_ready & event_enable_bits4_reg[7]) |=> alarm_out;
  endproperty
  a_vrdy: assert property (p_vrdy) else $error("ready alarm missed");

  sequence s_flag_clear;
    wr_ok & sel_cb & wd[7] & !any_alarm;
  endsequence
  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_b) s_flag_clear |=> !alarm_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_answer;
    @(posedge ref_clk) disable iff (!rst_b)
      ((read | write) & waitrequest) |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in one cycle");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_b)
      (read & sel_gs & !waitrequest) |-> (readdata[7:4] == 4'h0) && (readdata[3:0] == $past(pin_level_in));
  endproperty
  a_status: assert property (p_status) else $error("pin status wrong");

  property p_aux3_under;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[6] & aux_conv_done & (aux3_value < aux3_min))
        |=> limit_fault_bits3_reg[6];
  endproperty
  a_aux3_under: assert property (p_aux3_under) else $error("aux3 under fault not set");

  property p_aux4_over;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[5] & aux_conv_done & (aux4_value > aux4_max))
        |=> limit_fault_bits3_reg[5];
  endproperty
  a_aux4_over: assert property (p_aux4_over) else $error("aux4 over fault not set");

  property p_aux4_under;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[4] & aux_conv_done & (aux4_value < aux4_min))
        |=> limit_fault_bits3_reg[4];
  endproperty
  a_aux4_under: assert property (p_aux4_under) else $error("aux4 under fault not set");

  property p_isum_over;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[3] & isum_conv_done & (isum_value > isum_max))
        |=> limit_fault_bits3_reg[3];
  endproperty
  a_isum_over: assert property (p_isum_over) else $error("isum over fault not set");

  property p_isum_under;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[2] & isum_conv_done & (isum_value < isum_min))
        |=> limit_fault_bits3_reg[2];
  endproperty
  a_isum_under: assert property (p_isum_under) else $error("isum under fault not set");

  property p_psum_over;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[1] & psum_conv_done & (psum_value > psum_max))
        |=> limit_fault_bits3_reg[1];
  endproperty
  a_psum_over: assert property (p_psum_over) else $error("psum over fault not set");

  property p_psum_under;
    @(posedge ref_clk) disable iff (!rst_b)
      (limit_enable_bits3_reg[0] & psum_conv_done & (psum_value < psum_min))
        |=> limit_fault_bits3_reg[0];
  endproperty
  a_psum_under: assert property (p_psum_under) else $error("psum under fault not set");

  property p_isum_strict;
    @(posedge ref_clk) disable iff (!rst_b)
      (!limit_fault_bits3_reg[3] & !(isum_value > isum_max)) |=> !limit_fault_bits3_reg[3];
  endproperty
  a_isum_strict: assert property (p_isum_strict) else $error("isum fault at max");

  property p_no_strobe;
    @(posedge ref_clk) disable iff (!rst_b)
      (!limit_fault_bits3_reg[7] & !aux_conv_done) |=> !limit_fault_bits3_reg[7];
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("fault set without strobe");

  property p_aux_disabled;
    @(posedge ref_clk) disable iff (!rst_b)
      (!limit_fault_bits3_reg[6] & !limit_enable_bits3_reg[6]) |=> !limit_fault_bits3_reg[6];
  endproperty
  a_aux_disabled: assert property (p_aux_disabled) else $error("aux3 fault while off");

  property p_lf3_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_ok & sel_lf3 & !wd[7] & !limit_set[7]) |=> !limit_fault_bits3_reg[7];
  endproperty
  a_lf3_clear: assert property (p_lf3_clear) else $error("fault not cleared by write");

  property p_le3_write;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_ok & sel_le3) |=> (limit_enable_bits3_reg == $past(writedata[7:0]));
  endproperty
  a_le3_write: assert property (p_le3_write) else $error("limit enable not stored");

  property p_le3_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !(wr_ok & sel_le3) |=> $stable(limit_enable_bits3_reg);
  endproperty
  a_le3_hold: assert property (p_le3_hold) else $error("limit enable changed");

  property p_ee4_write;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_ok & sel_ee4) |=> (event_enable_bits4_reg == ($past(writedata[7:0]) & 8'hDE));
  endproperty
  a_ee4_write: assert property (p_ee4_write) else $error("event enable not stored");

  property p_gio_write;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_ok & sel_gio) |=> (pin_io_control_bits_reg == ($past(writedata[7:0]) & 8'h0E));
  endproperty
  a_gio_write: assert property (p_gio_write) else $error("polarity not stored");

  property p_pin2_fault;
    @(posedge ref_clk) disable iff (!rst_b)
      (event_enable_bits4_reg[2] & (pin_level_in[2] == pin_io_control_bits_reg[2]))
        |=> event_fault_bits4_reg[2];
  endproperty
  a_pin2_fault: assert property (p_pin2_fault) else $error("pin2 fault missed");

  property p_pin3_fault;
    @(posedge ref_clk) disable iff (!rst_b)
      (event_enable_bits4_reg[1] & (pin_level_in[1] == pin_io_control_bits_reg[1]))
        |=> event_fault_bits4_reg[1];
  endproperty
  a_pin3_fault: assert property (p_pin3_fault) else $error("pin3 fault missed");

  property p_pin_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (!event_fault_bits4_reg[3] & !event_enable_bits4_reg[3]) |=> !event_fault_bits4_reg[3];
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("pin1 fault while off");

  property p_wake_ctrl;
    @(posedge ref_clk) disable iff (!rst_b)
      (!event_fault_bits4_reg[4] & !stuck_wake_enable) |=> !event_fault_bits4_reg[4];
  endproperty
  a_wake_ctrl: assert property (p_wake_ctrl) else $error("wake fault without control");

  property p_wake_alarm;
    @(posedge ref_clk) disable iff (!rst_b)
      (stuck_wake & stuck_wake_enable & event_enable_bits4_reg[4]) |=> alarm_out;
  endproperty
  a_wake_alarm: assert property (p_wake_alarm) else $error("wake alarm missed");

  property p_irdy;
    @(posedge ref_clk) disable iff (!rst_b)
      (current_ready & event_enable_bits4_reg[6]) |=> alarm_out;
  endproperty
  a_irdy: assert property (p_irdy) else $error("current ready alarm missed");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      (alarm_out & !flag_clr) |=> alarm_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("alarm flag dropped");

  sequence s_gc_clear;
    wr_ok & sel_gc & !wd[mafb_pkg::MAFB_GC_FLAG_BIT] & !any_alarm;
  endsequence
  property p_gc_clear;
    @(posedge ref_clk) disable iff (!rst_b) s_gc_clear |=> !alarm_out;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("flag not cleared by write");

  property p_flag_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (!alarm_out & !any_alarm) |=> !alarm_out;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("alarm without cause");

  property p_limit_alarm;
    @(posedge ref_clk) disable iff (!rst_b)
      (|limit_set) |=> alarm_out;
  endproperty
  a_limit_alarm: assert property (p_limit_alarm) else $error("limit alarm missed");

  property p_ef4_read;
    @(posedge ref_clk) disable iff (!rst_b)
      (read & sel_ef4 & !waitrequest) |-> (readdata[7:5] == 3'b000) && !readdata[0];
  endproperty
  a_ef4_read: assert property (p_ef4_read) else $error("reserved fault bit read");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!rst_b)
      (read & !mapped & !waitrequest) |-> response_err && (readdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_ok & sel_cb) |=> (stuck_wake_enable == $past(writedata[4]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("wake control not stored");
endmodule // mafb_bank

// >>> hw/mafb_pkg.sv
// Package: register map, field positions and reset values of the alarm/fault bank
// Functional notes
// - Limit enable bits 7 and 6 arm aux channel 3 over and under alarms.
// - Limit enable bits 5 and 4 arm aux channel 4 over and under alarms.
// - Limit enable bits 3 and 2 arm summed current over and under alarms.
// - Limit enable bits 1 and 0 arm summed power over and under alarms.
// - Fault bits 7 and 6 flag aux channel 3 above max, below min.
// - Fault bits 5 and 4 flag aux channel 4 above max, below min.
// - Fault bits 3 and 2 flag summed current above max, below min.
// - Fault bits 1 and 0 flag summed power above max, below min.
// - Event enable bit 7 alarms on voltage converter data ready.
// - Event enable bit 6 alarms on current converters data ready.
// - Event enable bit 4 plus wakeup control alarms on stuck-bus shutdown exit.
// - Event fault bit 4 set on stuck-bus wakeup exit with control set.
// - Event enable bits 3,2,1 arm input-level alarms of pins 1,2,3.
// - Event fault bits 3,2,1 set when pins 1,2,3 seen at alarm level.
// - Pin I/O control bits 3,2,1 choose alarm level of pins 1,2,3.
// - Event fault bits 7..5,0 and enable bits 5,0 read zero, ignore writes.
// - Pin status bits 3..0 show live levels of pins 1 to 4.
// - Pin status bits 7..4 read zero, writes ignored.
// - Polarity 1 means high alarm level; pins 1,2 default low, pin 3 high.
// - Alarm-generated flag latches on alarms; cleared by writing 0 or clear bit.
package mafb_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] MAFB_IDX_LIMIT_ENABLE3 = 8'h91;
  localparam logic [7:0] MAFB_IDX_LIMIT_LIMIT_FAULT_GROUP3 = 8'h92;
  localparam logic [7:0] MAFB_IDX_EVENT_ENABLE4 = 8'h93;
  localparam logic [7:0] MAFB_IDX_EVENT_EVENT_FAULT_GROUP4 = 8'h94;
  localparam logic [7:0] MAFB_IDX_PIN_STATUS = 8'h95;
  localparam logic [7:0] MAFB_IDX_PIN_IO_CTRL = 8'h96;
  localparam logic [7:0] MAFB_IDX_PIN4_CTRL = 8'h97;
  localparam logic [7:0] MAFB_IDX_CONTROL_B = 8'h98;
  localparam int MAFB_ADDR_W = 10;
  localparam logic [7:0] MAFB_EVENT4_MASK = 8'hDE;
  localparam logic [7:0] MAFB_EVENT_FAULT_GROUP4_MASK = 8'h1E;
  localparam logic [7:0] MAFB_PIN_IO_MASK = 8'h0E;
  localparam logic [7:0] MAFB_PIN_IO_RESET = 8'h02;
  localparam logic [7:0] MAFB_SECOND_CONTROL_REGISTER_MASK = 8'h90;
  localparam int MAFB_SECOND_CONTROL_REGISTER_CLEAR_BIT = 7;
  localparam int MAFB_SECOND_CONTROL_REGISTER_WAKE_BIT = 4;
  localparam int MAFB_GC_FLAG_BIT = 7;
  localparam int MAFB_F4_WAKE_BIT = 4;
  localparam int MAFB_VRDY_BIT = 7;
  localparam int MAFB_IRDY_BIT = 6;
  localparam int MAFB_VAL_W = 24;
endpackage : mafb_pkg

// >>> tb/mafb_host.sv
// Avalon-MM host model standing in for the register-bus side
module mafb_host (
  input wire logic ref_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic response_err,
  output logic [9:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end
  // Request stands until waitrequest is sampled low at a rising edge; data is taken there
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, wd};
    byteenable <= 4'hF;
    forever begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    err = response_err;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule // mafb_host

// >>> tb/mafb_bank_test.sv
// Self-checking bench for the alarm/fault bank
module mafb_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, read, write, waitrequest, response_err, stuck_wake_enable, alarm_out;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, pin_level_in;
  logic [23:0] val, mx, mn;
  logic aux_c, isum_c, psum_c, v_rdy, i_rdy, s_wake;
  int err_count, checked;
  mafb_host host (.ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
    .response_err(response_err), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));
  mafb_bank uut (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response_err(response_err), .aux3_value(val),
    .aux4_value(val), .isum_value(val), .psum_value(val), .aux3_max(mx), .aux3_min(mn),
    .aux4_max(mx), .aux4_min(mn), .isum_max(mx), .isum_min(mn), .psum_max(mx),
    .psum_min(mn), .aux_conv_done(aux_c), .isum_conv_done(isum_c),
    .psum_conv_done(psum_c), .voltage_ready(v_rdy), .current_ready(i_rdy),
    .stuck_wake(s_wake), .pin_level_in(pin_level_in),
    .stuck_wake_enable(stuck_wake_enable), .alarm_out(alarm_out));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    host.xfer(1'b1, idx, wd, d, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic e;
    host.xfer(1'b0, idx, 8'h00, d, e);
    cmp(d, {24'h0, exp});
    cmp_bit(e, 1'b0);
  endtask
  // Strobes: aux, isum, psum, voltage ready, current ready, stuck wake
  task automatic pulse(input logic [23:0] v, input logic [5:0] m);
    @(posedge ref_clk);
    val <= v;
    {aux_c, isum_c, psum_c, v_rdy, i_rdy, s_wake} <= m;
    @(posedge ref_clk);
    {aux_c, isum_c, psum_c, v_rdy, i_rdy, s_wake} <= 6'h00;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic e;
    rd(8'h91, 8'h00);
    rd(8'h92, 8'h00);
    rd(8'h93, 8'h00);
    rd(8'h94, 8'h00);
    rd(8'h96, 8'h02);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b0);
    host.xfer(1'b0, 8'h90, 8'h00, d, e);
    cmp_bit(e, 1'b1);
    cmp(d, 32'h0);
  endtask
  task automatic t_limits;
    wr(8'h91, 8'hFF);
    rd(8'h91, 8'hFF);
    pulse(24'd100, 6'h38);
    rd(8'h92, 8'hAA);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b1);
    wr(8'h92, 8'h00);
    rd(8'h92, 8'h00);
    pulse(24'd5, 6'h38);
    rd(8'h92, 8'h55);
    wr(8'h92, 8'h00);
    pulse(24'd50, 6'h38);
    pulse(24'd10, 6'h38);
    rd(8'h92, 8'h00);
    pulse(24'd100, 6'h08);
    rd(8'h92, 8'h02);
    wr(8'h92, 8'h00);
    pulse(24'd5, 6'h10);
    rd(8'h92, 8'h04);
    wr(8'h92, 8'h00);
    pulse(24'd100, 6'h20);
    rd(8'h92, 8'hA0);
    wr(8'h92, 8'h00);
    wr(8'h91, 8'h00);
    pulse(24'd100, 6'h38);
    rd(8'h92, 8'h00);
  endtask
  task automatic t_events;
    wr(8'h93, 8'hFF);
    rd(8'h93, 8'hDE);
    @(posedge ref_clk) pin_level_in <= 4'b0110;
    rd(8'h94, 8'h0A);
    rd(8'h95, 8'h06);
    @(posedge ref_clk) pin_level_in <= 4'b1101;
    wr(8'h94, 8'hFF);
    rd(8'h94, 8'h0A);
    wr(8'h94, 8'h00);
    rd(8'h94, 8'h00);
    wr(8'h95, 8'hFF);
    rd(8'h95, 8'h0D);
    // Setting every polarity high turns idle pins 1 and 2 into hits
    wr(8'h96, 8'hFF);
    rd(8'h96, 8'h0E);
    rd(8'h94, 8'h0C);
    @(posedge ref_clk) pin_level_in <= 4'b0001;
    wr(8'h94, 8'h00);
    rd(8'h94, 8'h00);
    wr(8'h98, 8'h10);
    @(negedge ref_clk) cmp_bit(stuck_wake_enable, 1'b1);
    pulse(val, 6'h01);
    rd(8'h94, 8'h10);
    wr(8'h98, 8'h90);
    rd(8'h97, 8'h00);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b0);
    pulse(val, 6'h04);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b1);
    wr(8'h97, 8'h00);
    rd(8'h97, 8'h00);
    wr(8'h93, 8'h40);
    pulse(val, 6'h04);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b0);
    pulse(val, 6'h02);
    @(negedge ref_clk) cmp_bit(alarm_out, 1'b1);
  endtask
  task automatic summarize;
    $display("errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    summarize;
  end
  initial begin
    rst_b = 1'b0;
    pin_level_in = 4'b1101;
    val = 24'd0;
    mx = 24'd50;
    mn = 24'd10;
    {aux_c, isum_c, psum_c, v_rdy, i_rdy, s_wake} = 6'h00;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_limits;
    t_events;
    summarize;
  end
endmodule // mafb_bank_test
